// file: common/csb_pkg.sv
package csb_pkg;

  // clock and time units
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYC_DFLT   = MS_NS / CLK_PERIOD_NS;

  // time bases, full period in ms, toggling every half period
  localparam int unsigned TB_N          = 4;
  localparam int unsigned TB_10MS_MS    = 10;
  localparam int unsigned TB_100MS_MS   = 100;
  localparam int unsigned TB_1S_MS      = 1000;
  localparam int unsigned TB_1MIN_MS    = 60000;
  localparam int unsigned TB_CNT_W      = 16;

  // bus geometry
  localparam int unsigned ADR_W         = 8;
  localparam int unsigned DAT_W         = 32;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS      = 8'h00;
  localparam logic [7:0] OFS_MAX_SCAN   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;
  localparam logic [7:0] OFS_CTRL_STATE = 8'h10;

  // flag bit positions inside the flags register
  localparam int unsigned FB_COLD       = 0;
  localparam int unsigned FB_WARM       = 1;
  localparam int unsigned FB_TICK0      = 4;
  localparam int unsigned FB_FORCE_OFF  = 9;
  localparam int unsigned FB_LINK_OK    = 10;
  localparam int unsigned FB_WDOG       = 11;
  localparam int unsigned FB_RUNNING    = 12;
  localparam int unsigned FB_FIRST_RUN  = 13;

  // interrupt event bits
  localparam int unsigned IRQ_W         = 5;
  localparam int unsigned IB_COLD       = 0;
  localparam int unsigned IB_WARM       = 1;
  localparam int unsigned IB_LINK_LOST  = 2;
  localparam int unsigned IB_WDOG       = 3;
  localparam int unsigned IB_RUN_ENTRY  = 4;

  // reset values
  localparam logic        RST_LINK_OK   = 1'b1;
  localparam logic        RST_FIRST_RUN = 1'b1;
  localparam logic [15:0] RST_MAX_SCAN  = 16'h00FA;

  // controller state readback codes
  localparam logic [1:0] CODE_INIT      = 2'h0;
  localparam logic [1:0] CODE_STOP      = 2'h1;
  localparam logic [1:0] CODE_RUN       = 2'h2;
  localparam logic [1:0] CODE_HALT      = 2'h3;

  typedef enum {
    CS_INIT,
    CS_STOP,
    CS_RUN,
    CS_HALT
  } csb_state_t;

endpackage

// file: core/csb_status_bank.sv
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module csb_status_bank #(
  parameter int unsigned N_OUT  = 8,
  parameter int unsigned MS_CYC = csb_pkg::MS_CYC_DFLT
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // classic wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [csb_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [csb_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [csb_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                            wb_ack_o,
  // power supervisor and scan engine
  input  wire logic                       power_return_i,
  input  wire logic                       data_lost_i,
  input  wire logic                       init_done_i,
  input  wire logic                       run_cmd_i,
  input  wire logic                       stop_cmd_i,
  input  wire logic                       scan_start_i,
  input  wire logic                       scan_end_i,
  input  wire logic                       io_link_fault_i,
  input  wire logic [N_OUT-1:0]           out_image_i,
  // results
  output logic      [N_OUT-1:0]           outputs_o,
  output logic                            cold_restart_o,
  output logic      [csb_pkg::TB_N-1:0]   time_base_o,
  output logic                            running_o,
  output logic                            irq_o
);
  import csb_pkg::*;
  localparam int unsigned MS_W = $clog2(MS_CYC);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYC - 1);
  localparam int unsigned TB_MS [TB_N] = '{TB_10MS_MS, TB_100MS_MS,
                                           TB_1S_MS, TB_1MIN_MS};
  generate
    if (N_OUT < 1 || N_OUT > DAT_W || MS_CYC < 2) begin : g_bad_param
      $error("N_OUT must lie in 1..32, MS_CYC at least 2");
    end
  endgenerate
  logic                 bus_req;
  logic                 wr_lo;
  logic                 wr_hi;
  logic                 wr_flags;
  logic                 wr_max;
  logic                 wr_stat;
  logic                 wr_mask;
  logic [DAT_W-1:0]     rd_data;
  csb_state_t           state_r;
  csb_state_t           state_nxt;
  logic                 cold_r;
  logic                 cold_seen_r;
  logic                 warm_r;
  logic                 warm_seen_r;
  logic                 force_off_r;
  logic                 link_ok_r;
  logic                 wdog_r;
  logic                 run_flag_r;
  logic                 first_r;
  logic                 first_seen_r;
  logic [15:0]          max_scan_r;
  logic [IRQ_W-1:0]     irq_stat_r;
  logic [IRQ_W-1:0]     irq_mask_r;
  logic [IRQ_W-1:0]     irq_ev;
  logic [N_OUT-1:0]     outputs_r;
  logic                 ack_r;
  logic [DAT_W-1:0]     dat_r;
  logic                 cold_set;
  logic                 warm_set;
  logic                 wdog_trip;
  logic                 run_entry;
  logic                 link_lost;
  logic [MS_W-1:0]      ms_cnt_r;
  logic                 ms_tick;
  logic [15:0]          scan_ms_r;
  logic                 in_scan_r;
  logic [TB_N-1:0]      tb_r;
  logic                 lf_s1_r;
  logic                 lf_s2_r;
  logic                 lf_s3_r;
  logic                 lf_r;
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_lo    = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_hi    = bus_req & wb_we_i & wb_sel_i[1];
  assign wr_flags = wb_adr_i == OFS_FLAGS;
  assign wr_max   = wb_adr_i == OFS_MAX_SCAN;
  assign wr_stat  = wb_adr_i == OFS_IRQ_STAT;
  assign wr_mask  = wb_adr_i == OFS_IRQ_MASK;

  // wishbone: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_r <= rd_data;
      end
    end
  end
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      OFS_FLAGS: begin
        rd_data[FB_COLD]                  = cold_r;
        rd_data[FB_WARM]                  = warm_r;
        rd_data[FB_TICK0 +: TB_N]         = tb_r;
        rd_data[FB_FORCE_OFF]             = force_off_r;
        rd_data[FB_LINK_OK]               = link_ok_r;
        rd_data[FB_WDOG]                  = wdog_r;
        rd_data[FB_RUNNING]               = run_flag_r;
        rd_data[FB_FIRST_RUN]             = first_r;
      end
      OFS_MAX_SCAN:   rd_data[15:0]       = max_scan_r;
      OFS_IRQ_STAT:   rd_data[IRQ_W-1:0]  = irq_stat_r;
      OFS_IRQ_MASK:   rd_data[IRQ_W-1:0]  = irq_mask_r;
      OFS_CTRL_STATE: begin
        case (state_r)
          CS_INIT: rd_data[1:0] = CODE_INIT;
          CS_STOP: rd_data[1:0] = CODE_STOP;
          CS_RUN:  rd_data[1:0] = CODE_RUN;
          CS_HALT: rd_data[1:0] = CODE_HALT;
          default: rd_data[1:0] = CODE_INIT;
        endcase
      end
      default: rd_data = '0;
    endcase
  end

  // event sources
  assign cold_set  = (power_return_i & data_lost_i)
                   | (wr_lo & wr_flags & wb_dat_i[FB_COLD]);
  assign warm_set  = power_return_i & ~data_lost_i;
  assign wdog_trip = (state_r == CS_RUN) & in_scan_r
                   & (scan_ms_r > max_scan_r);
  assign run_entry = (state_r != CS_RUN) & (state_nxt == CS_RUN);
  assign link_lost = lf_r & link_ok_r;
  // cold restart request to the scan engine, one pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cold_restart_o <= 1'b0;
    end else begin
      cold_restart_o <= cold_set;
    end
  end

  // controller state: cold restart beats watchdog beats commands
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CS_INIT: if (init_done_i) state_nxt = CS_STOP;
      CS_STOP: if (run_cmd_i) state_nxt = CS_RUN;
      CS_RUN: begin
        if (wdog_trip) begin
          state_nxt = CS_HALT;
        end else if (stop_cmd_i) begin
          state_nxt = CS_STOP;
        end
      end
      CS_HALT: if (stop_cmd_i) state_nxt = CS_STOP;
      default: state_nxt = CS_INIT;
    endcase
    if (cold_set) begin
      state_nxt = CS_INIT;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= CS_INIT;
      run_flag_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      run_flag_r <= state_nxt == CS_RUN;
    end
  end

  // cold flag: held across one complete scan, cleared at its end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cold_r      <= 1'b0;
      cold_seen_r <= 1'b0;
    end else if (cold_set) begin
      cold_r      <= 1'b1;
      cold_seen_r <= 1'b0;
    end else if (cold_r && scan_start_i) begin
      cold_seen_r <= 1'b1;
    end else if (cold_seen_r && scan_end_i) begin
      cold_r      <= 1'b0;
      cold_seen_r <= 1'b0;
    end
  end

  // warm flag: no write path at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warm_r      <= 1'b0;
      warm_seen_r <= 1'b0;
    end else if (warm_set) begin
      warm_r      <= 1'b1;
      warm_seen_r <= 1'b0;
    end else if (warm_r && scan_start_i) begin
      warm_seen_r <= 1'b1;
    end else if (warm_seen_r && scan_end_i) begin
      warm_r      <= 1'b0;
      warm_seen_r <= 1'b0;
    end
  end

  // force-off bit belongs to software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_off_r <= 1'b0;
    end else if (wr_hi && wr_flags) begin
      force_off_r <= wb_dat_i[FB_FORCE_OFF];
    end
  end

  // outputs: image copied at scan end, forced low at once when asked in the run state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      outputs_r <= '0;
    end else if (force_off_r && state_r == CS_RUN) begin
      outputs_r <= '0;
    end else if (scan_end_i) begin
      outputs_r <= out_image_i;
    end
  end

  // link fault: three flops, a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lf_s1_r <= 1'b0;
      lf_s2_r <= 1'b0;
      lf_s3_r <= 1'b0;
      lf_r    <= 1'b0;
    end else begin
      lf_s1_r <= io_link_fault_i;
      lf_s2_r <= lf_s1_r;
      lf_s3_r <= lf_s2_r;
      if (lf_s2_r == lf_s3_r) begin
        lf_r <= lf_s3_r;
      end
    end
  end
  // health flag returns to one when the fault is gone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_ok_r <= RST_LINK_OK;
    end else begin
      link_ok_r <= ~lf_r;
    end
  end

  // 1 ms prescaler shared by time bases and watchdog
  assign ms_tick = ms_cnt_r == MS_LAST;
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end
  // free-running toggles, never touched by scan events
  generate
    for (genvar g = 0; g < TB_N; g++) begin : g_tb
      localparam logic [TB_CNT_W-1:0] HALF_LAST =
        TB_CNT_W'(TB_MS[g] / 2 - 1);
      logic [TB_CNT_W-1:0] cnt_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_r   <= '0;
          tb_r[g] <= 1'b0;
        end else if (ms_tick) begin
          if (cnt_r == HALF_LAST) begin
            cnt_r   <= '0;
            tb_r[g] <= ~tb_r[g];
          end else begin
            cnt_r   <= cnt_r + 1'b1;
          end
        end
      end
    end
  endgenerate

  // scan time in whole ms; resolution limits watchdog to +-1 ms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_scan_r <= 1'b0;
      scan_ms_r <= '0;
    end else if (scan_start_i) begin
      in_scan_r <= 1'b1;
      scan_ms_r <= '0;
    end else if (scan_end_i) begin
      in_scan_r <= 1'b0;
    end else if (in_scan_r && ms_tick && scan_ms_r != '1) begin
      scan_ms_r <= scan_ms_r + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_scan_r <= RST_MAX_SCAN;
    end else if (wr_max) begin
      if (wr_lo) begin
        max_scan_r[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi) begin
        max_scan_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // watchdog flag sticks until the next cold restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_r <= 1'b0;
    end else if (wdog_trip) begin
      wdog_r <= 1'b1;
    end else if (cold_set) begin
      wdog_r <= 1'b0;
    end
  end

  // first-run flag: high from reset and at each run entry, ends with the first scan in run or on reaching stop or halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_r      <= RST_FIRST_RUN;
      first_seen_r <= 1'b0;
    end else if (run_entry) begin
      first_r      <= 1'b1;
      first_seen_r <= 1'b0;
    end else if (first_r && state_r == CS_RUN && scan_start_i) begin
      first_seen_r <= 1'b1;
    end else if (first_seen_r && scan_end_i) begin
      first_r      <= 1'b0;
      first_seen_r <= 1'b0;
    end else if (state_r != CS_RUN && state_r != CS_INIT) begin
      first_r      <= 1'b0;
      first_seen_r <= 1'b0;
    end
  end

  // interrupts: set beats write-one-to-clear
  always_comb begin
    irq_ev               = '0;
    irq_ev[IB_COLD]      = cold_set;
    irq_ev[IB_WARM]      = warm_set;
    irq_ev[IB_LINK_LOST] = link_lost;
    irq_ev[IB_WDOG]      = wdog_trip;
    irq_ev[IB_RUN_ENTRY] = run_entry;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (wr_lo && wr_stat) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      if (wr_lo && wr_mask) begin
        irq_mask_r <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  assign irq_o       = |(irq_stat_r & irq_mask_r);
  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = dat_r;
  assign outputs_o   = outputs_r;
  assign time_base_o = tb_r;
  assign running_o   = run_flag_r;
endmodule
`default_nettype wire

// file: test/csb_status_bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
module csb_status_bank_chk #(
  parameter int unsigned N_OUT  = 8,
  parameter int unsigned MS_CYC = csb_pkg::MS_CYC_DFLT
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [csb_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [csb_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic                      wb_ack_o,
  input wire logic                      power_return_i,
  input wire logic                      data_lost_i,
  input wire logic                      run_cmd_i,
  input wire logic                      stop_cmd_i,
  input wire logic                      scan_end_i,
  input wire logic [N_OUT-1:0]          out_image_i,
  input wire logic [N_OUT-1:0]          outputs_o,
  input wire logic                      cold_restart_o,
  input wire logic [csb_pkg::TB_N-1:0]  time_base_o,
  input wire logic                      running_o,
  input wire logic                      irq_o
);
  import csb_pkg::*;
  localparam int H0 = (TB_10MS_MS / 2) * MS_CYC;
  logic [31:0] tk_cnt_r;
  logic        tk_seen_r;
  logic        tk_q_r;
  logic        req;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // half-period count, armed only after a first toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tk_cnt_r  <= 32'h0;
      tk_seen_r <= 1'h0;
      tk_q_r    <= 1'h0;
    end else begin
      tk_q_r <= time_base_o[0];
      if (time_base_o[0] != tk_q_r) begin
        tk_cnt_r  <= 32'h1;
        tk_seen_r <= 1'h1;
      end else begin
        tk_cnt_r <= tk_cnt_r + 32'h1;
      end
    end
  end

  a_cold_power: assert property (power_return_i && data_lost_i
    |=> cold_restart_o) else $error("no cold pulse after data loss");
  a_cold_write: assert property (req && wb_we_i && wb_sel_i[0]
    && wb_adr_i == OFS_FLAGS && wb_dat_i[0] |=> cold_restart_o)
    else $error("no cold pulse after flag write");
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(req) ##1 !wb_ack_o)
    else $error("ack without request or too long");
  a_stop_run: assert property (running_o && stop_cmd_i
    && !power_return_i |=> !running_o) else $error("running after stop");
  a_run_cause: assert property ($rose(running_o) |-> $past(run_cmd_i))
    else $error("running without run command");
  a_tick_period: assert property (tk_seen_r
    && time_base_o[0] != tk_q_r |-> tk_cnt_r == H0)
    else $error("fast time base half period wrong");
  a_tick_late: assert property (tk_seen_r |-> tk_cnt_r <= H0)
    else $error("fast time base stalled");
  a_out_image: assert property (!running_o && !run_cmd_i
    && scan_end_i |=> outputs_o == $past(out_image_i))
    else $error("outputs not loaded from image");

  c_cold: cover property (cold_restart_o);
  c_halt: cover property ($fell(running_o) && !$past(stop_cmd_i));
  c_irq: cover property (irq_o);
endmodule
bind csb_status_bank csb_status_bank_chk #(.N_OUT(N_OUT), .MS_CYC(MS_CYC))
  i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .power_return_i(power_return_i), .data_lost_i(data_lost_i),
  .run_cmd_i(run_cmd_i), .stop_cmd_i(stop_cmd_i), .scan_end_i(scan_end_i),
  .out_image_i(out_image_i), .outputs_o(outputs_o),
  .cold_restart_o(cold_restart_o), .time_base_o(time_base_o),
  .running_o(running_o), .irq_o(irq_o));
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csb_pkg::*;
  localparam int MSC = 4;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        power_return_i = 1'h0, data_lost_i = 1'h0;
  logic        init_done_i = 1'h0, run_cmd_i = 1'h0, stop_cmd_i = 1'h0;
  logic        scan_start_i = 1'h0, scan_end_i = 1'h0;
  logic        io_link_fault_i = 1'h0;
  logic [7:0]  out_image_i = 8'h0;
  logic [31:0] wb_dat_o, rd_q;
  logic [7:0]  outputs_o;
  logic [3:0]  time_base_o;
  logic        wb_ack_o, cold_restart_o, running_o, irq_o, cr_q;
  int          err_total = 0, n_checks = 0, cyc_n = 0;

  csb_status_bank #(.N_OUT(8), .MS_CYC(MSC)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .power_return_i(power_return_i), .data_lost_i(data_lost_i),
    .init_done_i(init_done_i), .run_cmd_i(run_cmd_i),
    .stop_cmd_i(stop_cmd_i), .scan_start_i(scan_start_i),
    .scan_end_i(scan_end_i), .io_link_fault_i(io_link_fault_i),
    .out_image_i(out_image_i), .outputs_o(outputs_o),
    .cold_restart_o(cold_restart_o), .time_base_o(time_base_o),
    .running_o(running_o), .irq_o(irq_o));

  always #10 clk_i = ~clk_i;

  // tick tests dominate the run time
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle, no assumed latency
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    rd_q = wb_dat_o;
    cr_q = cold_restart_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    wb(1'h0, a, 32'h0, 4'hF);
    chk(nm, e, rd_q & m);
  endtask

  // 0 init done, 1 run, 2 stop, 3 scan start, 4 scan end
  task automatic pls(input int k);
    case (k)
      0: init_done_i <= 1'h1;
      1: run_cmd_i <= 1'h1;
      2: stop_cmd_i <= 1'h1;
      3: scan_start_i <= 1'h1;
      default: scan_end_i <= 1'h1;
    endcase
    @(posedge clk_i);
    {init_done_i, run_cmd_i, stop_cmd_i, scan_start_i, scan_end_i} <= 5'h0;
    @(posedge clk_i);
  endtask

  task automatic pwr(input logic lost);
    power_return_i <= 1'h1;
    data_lost_i    <= lost;
    @(posedge clk_i);
    power_return_i <= 1'h0;
    @(posedge clk_i);
    chk("cold_out", {31'h0, lost}, {31'h0, cold_restart_o});
  endtask

  task automatic t_reset();
    rdc("flags", OFS_FLAGS, 32'hFFFFFF0F, 32'h2400);
    rdc("max_scan", OFS_MAX_SCAN, 32'hFFFFFFFF, 32'hFA);
    rdc("state", OFS_CTRL_STATE, 32'hFFFFFFFF, 32'h0);
    rdc("irq_stat", OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    rdc("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_cold();
    pwr(1'h1);
    rdc("cold_set", OFS_FLAGS, 32'h1, 32'h1);
    pls(3);
    rdc("cold_scan", OFS_FLAGS, 32'h1, 32'h1);
    pls(4);
    rdc("cold_clr", OFS_FLAGS, 32'h1, 32'h0);
    wb(1'h1, OFS_IRQ_MASK, 32'h1, 4'hF);
    chk("irq_on", 32'h1, {31'h0, irq_o});
    wb(1'h1, OFS_IRQ_MASK, 32'h0, 4'hF);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wb(1'h1, OFS_IRQ_MASK, 32'h1, 4'hF);
    wb(1'h1, OFS_IRQ_STAT, 32'h1, 4'hF);
    chk("irq_clr", 32'h0, {31'h0, irq_o});
    $display("test cold done");
  endtask

  task automatic t_warm();
    pwr(1'h0);
    rdc("warm_set", OFS_FLAGS, 32'h3, 32'h2);
    wb(1'h1, OFS_FLAGS, 32'h0, 4'h1);
    rdc("warm_ro", OFS_FLAGS, 32'h3, 32'h2);
    pls(3);
    pls(4);
    rdc("warm_clr", OFS_FLAGS, 32'h3, 32'h0);
    $display("test warm done");
  endtask

  task automatic t_run();
    pls(0);
    rdc("stop", OFS_CTRL_STATE, 32'h3, 32'h1);
    pls(1);
    chk("running", 32'h1, {31'h0, running_o});
    rdc("run_flags", OFS_FLAGS, 32'hFFFFFF0F, 32'h3400);
    out_image_i <= 8'hA5;
    pls(3);
    pls(4);
    chk("outputs", 32'hA5, {24'h0, outputs_o});
    rdc("first_clr", OFS_FLAGS, 32'hFFFFFF0F, 32'h1400);
    wb(1'h1, OFS_FLAGS, 32'h200, 4'h2);
    chk("forced", 32'h0, {24'h0, outputs_o});
    rdc("force_rd", OFS_FLAGS, 32'hFFFFFF0F, 32'h1600);
    out_image_i <= 8'h5A;
    pls(3);
    pls(4);
    chk("forced_scan", 32'h0, {24'h0, outputs_o});
    wb(1'h1, OFS_FLAGS, 32'h0, 4'h2);
    out_image_i <= 8'h3C;
    pls(3);
    pls(4);
    chk("unforced", 32'h3C, {24'h0, outputs_o});
    pls(2);
    chk("run_stopped", 32'h0, {31'h0, running_o});
    pls(1);
    $display("test run done");
  endtask

  task automatic t_wdog();
    int n;
    n = 0;
    wb(1'h1, OFS_MAX_SCAN, 32'h2, 4'hF);
    pls(3);
    while (running_o !== 1'h0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("halted", 32'h0, {31'h0, running_o});
    rdc("wdog", OFS_FLAGS, 32'h800, 32'h800);
    rdc("halt", OFS_CTRL_STATE, 32'h3, 32'h3);
    pls(2);
    rdc("stopped", OFS_CTRL_STATE, 32'h3, 32'h1);
    $display("test watchdog done");
  endtask

  task automatic t_link();
    io_link_fault_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    rdc("link_lost", OFS_FLAGS, 32'h400, 32'h0);
    rdc("link_irq", OFS_IRQ_STAT, 32'h1F, 32'h1E);
    io_link_fault_i <= 1'h0;
    $display("test link done");
  endtask

  task automatic t_tick(input int b, input int h);
    int n;
    logic v;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      v = time_base_o[b];
      while (time_base_o[b] === v && n < 3 * h) begin
        @(posedge clk_i);
        n++;
      end
    end
    chk("tick_half", 32'(h), 32'(n));
    $display("test tick %0d done", b);
  endtask

  task automatic t_cold_wr();
    wb(1'h1, OFS_FLAGS, 32'h1, 4'h1);
    chk("cold_wr_out", 32'h1, {31'h0, cr_q});
    rdc("cold_wr", OFS_FLAGS, 32'h801, 32'h1);
    rdc("cold_init", OFS_CTRL_STATE, 32'h3, 32'h0);
    pls(3);
    pls(4);
    rdc("cold_wr_clr", OFS_FLAGS, 32'h1, 32'h0);
    $display("test cold write done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_cold();
    t_warm();
    t_run();
    t_wdog();
    t_link();
    t_tick(0, 5 * MSC);
    t_tick(1, 50 * MSC);
    t_tick(2, 500 * MSC);
    t_cold_wr();
    complete_run();
  end
endmodule
`default_nettype wire
